// File: ibd_defs.svh
// constants for the immediate branch and load/store decoder
`ifndef IBD_DEFS_SVH
`define IBD_DEFS_SVH

// ====================================================
// major opcodes, instruction bits 26-31
`define IBD_OP_JUMP_IMM 6'h2E
`define IBD_OP_COND_IMM 6'h2F
`define IBD_OP_LBU_REG 6'h30
`define IBD_OP_LHU_REG 6'h31
`define IBD_OP_LW_REG 6'h32
`define IBD_OP_SB_REG 6'h34
`define IBD_OP_SH_REG 6'h35
`define IBD_OP_SW_REG 6'h36
`define IBD_OP_LBU_IMM 6'h38
`define IBD_OP_LHU_IMM 6'h39
`define IBD_OP_LW_IMM 6'h3A
`define IBD_OP_SB_IMM 6'h3C
`define IBD_OP_SH_IMM 6'h3D
`define IBD_OP_SW_IMM 6'h3E

// ====================================================
// jump selectors, instruction bits 16-20
`define IBD_SEL_REL 5'h00
`define IBD_SEL_REL_D 5'h10
`define IBD_SEL_REL_LINK 5'h14
`define IBD_SEL_ABS 5'h08
`define IBD_SEL_ABS_D 5'h18
`define IBD_SEL_ABS_LINK 5'h1C
`define IBD_SEL_BREAK 5'h0C
`define IBD_SEL_DELAY_BIT 4

// ====================================================
// condition codes, instruction bits 21-25 (bit 4 = delayed)
`define IBD_CC_EQ 4'h0
`define IBD_CC_NE 4'h1
`define IBD_CC_LT 4'h2
`define IBD_CC_LE 4'h3
`define IBD_CC_GT 4'h4
`define IBD_CC_GE 4'h5
`define IBD_CC_DELAY_BIT 4

// ====================================================
// extended field, instruction bits 0-10
`define IBD_EXT_NORMAL 11'h000
`define IBD_EXT_REVERSED 11'h200
`define IBD_EXT_EXCL 11'h400

// ====================================================
// misc values
`define IBD_PC_STEP 32'h00000004
`define IBD_WORD_ZERO 32'h00000000
`define IBD_BE_WORD 4'hF
`define IBD_BE_BYTE0 4'h8
`define IBD_BE_HALF_HI 4'hC
`define IBD_BE_HALF_LO 4'h3

`endif

// File: ibd_pkg.sv
// types shared by the immediate branch and load/store decoder
package ibd_pkg;

  // ====================================================
  // sequencer states
  typedef enum logic [1:0] {
    IBD_IDLE,
    IBD_READ,
    IBD_EXEC,
    IBD_MEM
  } ibd_state_t;

  // ====================================================
  // load kinds waiting for data
  typedef enum logic [1:0] {
    IBD_LD_NONE,
    IBD_LD_BYTE,
    IBD_LD_HALF,
    IBD_LD_WORD
  } ibd_load_t;

  // ====================================================
  // data memory request carrier
  typedef struct packed {
    logic req;
    logic we;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ibd_mem_t;

endpackage

// File: ibd_regfile.sv
// general purpose register file, three registered read ports
`timescale 1ns/1ps
module ibd_regfile #(
  parameter int DW = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // read ports
  input wire logic [AW-1:0] raddr_a_i,
  input wire logic [AW-1:0] raddr_b_i,
  input wire logic [AW-1:0] raddr_c_i,
  output logic [DW-1:0] rdata_a_o,
  output logic [DW-1:0] rdata_b_o,
  output logic [DW-1:0] rdata_c_o
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] ra;
    logic [DW-1:0] rb;
    logic [DW-1:0] rc;
  } rf_state_t;

  rf_state_t state_reg;
  rf_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (we_i) begin
      state_next.mem[waddr_i] = wdata_i;
    end
    // register zero always reads as zero
    state_next.ra = (raddr_a_i == '0) ? '0 : state_reg.mem[raddr_a_i];
    state_next.rb = (raddr_b_i == '0) ? '0 : state_reg.mem[raddr_b_i];
    state_next.rc = (raddr_c_i == '0) ? '0 : state_reg.mem[raddr_c_i];
  end

  // the array itself is not reset, only the read registers
  always_ff @(posedge clk_sys_i) begin
    state_reg.mem <= state_next.mem;
    if (!rst_n_i) begin
      state_reg.ra <= '0;
      state_reg.rb <= '0;
      state_reg.rc <= '0;
    end else begin
      state_reg.ra <= state_next.ra;
      state_reg.rb <= state_next.rb;
      state_reg.rc <= state_next.rc;
    end
  end

  assign rdata_a_o = state_reg.ra;
  assign rdata_b_o = state_reg.rb;
  assign rdata_c_o = state_reg.rc;

endmodule // ibd_regfile

// File: ibd_core.sv
// decode and execute of immediate branches and loads/stores
`timescale 1ns/1ps
`include "ibd_defs.svh"
module ibd_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] instr_pc_i,
  output logic instr_ready_o,
  // completion
  output logic done_o,
  output logic [31:0] pc_next_o,
  output logic taken_o,
  output logic delay_slot_o,
  // status events and flags
  input wire logic irq_i,
  input wire logic exc_i,
  input wire logic bip_clear_i,
  output logic bip_o,
  output logic carry_o,
  output logic resv_o,
  // data memory port
  output ibd_pkg::ibd_mem_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);

  // ====================================================
  // state
  typedef struct packed {
    ibd_pkg::ibd_state_t st;
    logic rdy;
    logic [31:0] instr;
    logic [31:0] pc;
    ibd_pkg::ibd_mem_t mem;
    ibd_pkg::ibd_load_t ld;
    logic [1:0] off;
    logic done;
    logic [31:0] pc_next;
    logic taken;
    logic pend;
    logic [31:0] pend_tgt;
    logic wb_en;
    logic [4:0] wb_addr;
    logic [31:0] wb_data;
    logic resv;
    logic break_in_progress;
    logic carry;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  // ====================================================
  // register file
  logic [31:0] reg_a;
  logic [31:0] reg_b;
  logic [31:0] reg_d;

  ibd_regfile #(
    .DW(32),
    .AW(5)
  ) u_regfile (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .we_i(state_reg.wb_en),
    .waddr_i(state_reg.wb_addr),
    .wdata_i(state_reg.wb_data),
    .raddr_a_i(state_reg.instr[20:16]),
    .raddr_b_i(state_reg.instr[15:11]),
    .raddr_c_i(state_reg.instr[25:21]),
    .rdata_a_o(reg_a),
    .rdata_b_o(reg_b),
    .rdata_c_o(reg_d)
  );

  // ====================================================
  // field decode of the held instruction
  logic [5:0] opcode;
  logic [4:0] fld_d;
  logic [4:0] fld_a;
  logic [10:0] ext;
  logic [31:0] imm_s;
  logic [31:0] seq_pc;
  logic [31:0] rel_tgt;
  logic [31:0] addr_reg;
  logic [31:0] addr_imm;

  assign opcode = state_reg.instr[31:26];
  assign fld_d = state_reg.instr[25:21];
  assign fld_a = state_reg.instr[20:16];
  assign ext = state_reg.instr[10:0];
  assign imm_s = {{16{state_reg.instr[15]}}, state_reg.instr[15:0]};
  assign seq_pc = state_reg.pc + `IBD_PC_STEP;
  assign rel_tgt = state_reg.pc + imm_s;
  assign addr_reg = reg_a + reg_b;
  assign addr_imm = reg_a + imm_s;

  // condition on source register A, read as signed
  logic a_zero;
  logic a_neg;
  logic cond_true;

  assign a_zero = (reg_a == `IBD_WORD_ZERO);
  assign a_neg = reg_a[31];

  always_comb begin
    case (fld_d[3:0])
      `IBD_CC_EQ: cond_true = a_zero;
      `IBD_CC_NE: cond_true = !a_zero;
      `IBD_CC_LT: cond_true = a_neg;
      `IBD_CC_LE: cond_true = a_neg || a_zero;
      `IBD_CC_GT: cond_true = !a_neg && !a_zero;
      `IBD_CC_GE: cond_true = !a_neg;
      default: cond_true = 1'b0;
    endcase
  end

  // a valid condition code has only bit 4 free besides codes 0-5
  logic cond_valid;
  assign cond_valid = (fld_d[3:0] <= `IBD_CC_GE);

  // ====================================================
  // load/store decode
  logic is_mem;
  logic is_imm_form;
  logic is_store;
  logic excl;
  logic ext_ok;
  logic [1:0] size;
  logic [31:0] eff_addr;

  always_comb begin
    is_mem = 1'b0;
    is_store = 1'b0;
    size = 2'h0;
    case (opcode)
      `IBD_OP_LBU_REG, `IBD_OP_LBU_IMM: begin
        is_mem = 1'b1;
        size = 2'h1;
      end
      `IBD_OP_LHU_REG, `IBD_OP_LHU_IMM: begin
        is_mem = 1'b1;
        size = 2'h2;
      end
      `IBD_OP_LW_REG, `IBD_OP_LW_IMM: begin
        is_mem = 1'b1;
        size = 2'h3;
      end
      `IBD_OP_SB_REG, `IBD_OP_SB_IMM: begin
        is_mem = 1'b1;
        is_store = 1'b1;
        size = 2'h1;
      end
      `IBD_OP_SH_REG, `IBD_OP_SH_IMM: begin
        is_mem = 1'b1;
        is_store = 1'b1;
        size = 2'h2;
      end
      `IBD_OP_SW_REG, `IBD_OP_SW_IMM: begin
        is_mem = 1'b1;
        is_store = 1'b1;
        size = 2'h3;
      end
      default: begin
        is_mem = 1'b0;
      end
    endcase
  end

  // the reversed form is accepted and performs the plain access
  assign is_imm_form = opcode[3];
  assign excl = !is_imm_form && (size == 2'h3) &&
    (ext == `IBD_EXT_EXCL);
  assign ext_ok = is_imm_form || excl ||
    (ext == `IBD_EXT_NORMAL) || (ext == `IBD_EXT_REVERSED);
  // reserving accesses drop the low bits rather than fault
  assign eff_addr = excl ? {addr_reg[31:2], 2'h0} :
    (is_imm_form ? addr_imm : addr_reg);

  // ====================================================
  // store lanes, byte 0 of a word is the most significant lane
  logic [3:0] st_be;
  logic [31:0] st_data;

  always_comb begin
    case (size)
      2'h1: begin
        st_be = `IBD_BE_BYTE0 >> eff_addr[1:0];
        st_data = {4{reg_d[7:0]}};
      end
      2'h2: begin
        st_be = eff_addr[1] ? `IBD_BE_HALF_LO : `IBD_BE_HALF_HI;
        st_data = {2{reg_d[15:0]}};
      end
      default: begin
        st_be = `IBD_BE_WORD;
        st_data = reg_d;
      end
    endcase
  end

  // ====================================================
  // load data extraction
  logic [31:0] ld_data;

  always_comb begin
    case (state_reg.ld)
      ibd_pkg::IBD_LD_BYTE: begin
        ld_data = {24'h000000,
          mem_rdata_i[8*(3-state_reg.off) +: 8]};
      end
      ibd_pkg::IBD_LD_HALF: begin
        ld_data = state_reg.off[1] ? {16'h0000, mem_rdata_i[15:0]} :
          {16'h0000, mem_rdata_i[31:16]};
      end
      default: begin
        ld_data = mem_rdata_i;
      end
    endcase
  end

  // ====================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.wb_en = 1'b0;
    case (state_reg.st)
      ibd_pkg::IBD_IDLE: begin
        state_next.rdy = 1'b1;
        if (instr_valid_i && state_reg.rdy) begin
          state_next.instr = instr_i;
          state_next.pc = instr_pc_i;
          state_next.rdy = 1'b0;
          state_next.st = ibd_pkg::IBD_READ;
        end
      end
      ibd_pkg::IBD_READ: begin
        state_next.st = ibd_pkg::IBD_EXEC;
      end
      ibd_pkg::IBD_EXEC: begin
        // a slot instruction hands over to the held target
        state_next.pc_next = state_reg.pend ? state_reg.pend_tgt :
          seq_pc;
        state_next.taken = state_reg.pend;
        state_next.pend = 1'b0;
        state_next.done = 1'b1;
        state_next.st = ibd_pkg::IBD_IDLE;
        state_next.rdy = 1'b1;
        if (opcode == `IBD_OP_JUMP_IMM) begin
          case (fld_a)
            `IBD_SEL_REL, `IBD_SEL_REL_D, `IBD_SEL_REL_LINK: begin
              state_next.pend_tgt = rel_tgt;
              state_next.taken = 1'b1;
            end
            `IBD_SEL_ABS, `IBD_SEL_ABS_D, `IBD_SEL_ABS_LINK,
            `IBD_SEL_BREAK: begin
              state_next.pend_tgt = imm_s;
              state_next.taken = 1'b1;
            end
            default: begin
              state_next.taken = state_reg.pend;
            end
          endcase
          if (fld_a == `IBD_SEL_REL_LINK || fld_a == `IBD_SEL_ABS_LINK ||
              fld_a == `IBD_SEL_BREAK) begin
            state_next.wb_en = 1'b1;
            state_next.wb_addr = fld_d;
            state_next.wb_data = state_reg.pc;
          end
          if (fld_a == `IBD_SEL_BREAK) begin
            state_next.break_in_progress = 1'b1;
            state_next.resv = 1'b0;
          end
          if (state_next.taken && !state_reg.pend) begin
            if (fld_a[`IBD_SEL_DELAY_BIT]) begin
              state_next.pend = 1'b1;
              state_next.taken = 1'b0;
            end else begin
              state_next.pc_next = state_next.pend_tgt;
            end
          end
        end else if (opcode == `IBD_OP_COND_IMM && cond_valid &&
                     cond_true && !state_reg.pend) begin
          state_next.pend_tgt = rel_tgt;
          if (fld_d[`IBD_CC_DELAY_BIT]) begin
            state_next.pend = 1'b1;
          end else begin
            state_next.taken = 1'b1;
            state_next.pc_next = rel_tgt;
          end
        end else if (is_mem && ext_ok) begin
          state_next.done = 1'b0;
          state_next.rdy = 1'b0;
          state_next.pend = state_reg.pend;
          state_next.off = eff_addr[1:0];
          state_next.wb_addr = fld_d;
          if (excl && is_store && !state_reg.resv) begin
            // lost reservation: memory untouched, done at once
            state_next.carry = 1'b1;
            state_next.pend = 1'b0;
            state_next.done = 1'b1;
            state_next.rdy = 1'b1;
          end else begin
            state_next.mem.req = 1'b1;
            state_next.mem.we = is_store;
            state_next.mem.be = is_store ? st_be : `IBD_BE_WORD;
            state_next.mem.addr = eff_addr;
            state_next.mem.wdata = st_data;
            state_next.ld = is_store ? ibd_pkg::IBD_LD_NONE :
              ibd_pkg::ibd_load_t'(size);
            state_next.st = ibd_pkg::IBD_MEM;
            if (excl && is_store) begin
              state_next.carry = 1'b0;
            end
          end
          if (excl && is_store) begin
            state_next.resv = 1'b0;
          end
        end
      end
      ibd_pkg::IBD_MEM: begin
        if (mem_ack_i) begin
          state_next.mem.req = 1'b0;
          state_next.mem.we = 1'b0;
          state_next.wb_en = (state_reg.ld != ibd_pkg::IBD_LD_NONE);
          state_next.wb_data = ld_data;
          state_next.pend = 1'b0;
          state_next.done = 1'b1;
          state_next.rdy = 1'b1;
          state_next.st = ibd_pkg::IBD_IDLE;
        end
      end
      default: begin
        state_next.st = ibd_pkg::IBD_IDLE;
      end
    endcase
    // outside events drop the reservation; a reserving load set wins
    if (irq_i || exc_i) begin
      state_next.resv = 1'b0;
    end
    if (state_reg.st == ibd_pkg::IBD_EXEC && is_mem && ext_ok && excl &&
        !is_store) begin
      state_next.resv = 1'b1;
    end
    if (bip_clear_i && !state_next.break_in_progress) begin
      state_next.break_in_progress = 1'b0;
    end else if (bip_clear_i && state_reg.break_in_progress &&
                 !(state_reg.st == ibd_pkg::IBD_EXEC &&
                   opcode == `IBD_OP_JUMP_IMM &&
                   fld_a == `IBD_SEL_BREAK)) begin
      state_next.break_in_progress = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.st <= ibd_pkg::IBD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ====================================================
  // outputs, all straight from the state register
  assign instr_ready_o = state_reg.rdy;
  assign done_o = state_reg.done;
  assign pc_next_o = state_reg.pc_next;
  assign taken_o = state_reg.taken;
  assign delay_slot_o = state_reg.pend;
  assign bip_o = state_reg.break_in_progress;
  assign carry_o = state_reg.carry;
  assign resv_o = state_reg.resv;
  assign mem_o = state_reg.mem;

endmodule // ibd_core

// File: ibd_core_sva.sv
// port checker for the immediate branch and load/store core
`timescale 1ns/1ps
module ibd_core_sva (
  // clock and reset
  input logic clk_sys_i,
  input logic rst_n_i,
  // instruction stream
  input logic instr_valid_i,
  input logic [31:0] instr_i,
  input logic [31:0] instr_pc_i,
  input logic instr_ready_o,
  input logic done_o,
  input logic [31:0] pc_next_o,
  input logic taken_o,
  input logic delay_slot_o,
  // status
  input logic irq_i,
  input logic exc_i,
  input logic bip_clear_i,
  input logic bip_o,
  input logic carry_o,
  input logic resv_o,
  // data memory
  input ibd_pkg::ibd_mem_t mem_o,
  input logic mem_ack_i,
  input logic [31:0] mem_rdata_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==================================================
  // decode helpers; slot instructions always go to the held target, so skip them
  logic acc;
  logic excl;
  logic [5:0] op;
  logic [4:0] sel;
  logic [31:0] simm;
  assign acc = instr_valid_i && instr_ready_o && !delay_slot_o;
  assign excl = instr_i[10:0] == 11'h400;
  assign op = instr_i[31:26];
  assign sel = instr_i[20:16];
  assign simm = {{16{instr_i[15]}}, instr_i[15:0]};
  // ==================================================
  // assertions
  a_rel_jump: assert property (
    acc && op == 6'h2E && sel == 5'h00 |-> ##3 done_o && taken_o &&
    pc_next_o == $past(instr_pc_i, 3) + $past(simm, 3))
    else $error("relative jump target wrong");
  a_abs_jump: assert property (
    acc && op == 6'h2E && (sel == 5'h08 || sel == 5'h0C) |-> ##3 done_o &&
    taken_o && pc_next_o == $past(simm, 3))
    else $error("absolute jump target wrong");
  a_delayed_slot: assert property (
    acc && op == 6'h2E && sel[4] && sel[1:0] == 2'h0 |-> ##3 done_o &&
    !taken_o && delay_slot_o && pc_next_o == $past(instr_pc_i, 3) + 32'h4)
    else $error("delayed jump did not run its slot first");
  a_cond_branch: assert property (
    acc && op == 6'h2F && !instr_i[25] |-> ##3 done_o && pc_next_o ==
    $past(instr_pc_i, 3) + (taken_o ? $past(simm, 3) : 32'h4))
    else $error("conditional branch next address wrong");
  a_break_flag: assert property (
    acc && op == 6'h2E && sel == 5'h0C |-> ##3 bip_o && !resv_o)
    else $error("break jump flags wrong");
  a_byte_lanes: assert property (
    acc && (op == 6'h3C || op == 6'h34 && instr_i[10:0] inside {11'h000,
    11'h200}) |-> ##3 mem_o.req && mem_o.we &&
    $onehot(mem_o.be) && mem_o.wdata == {4{mem_o.wdata[7:0]}})
    else $error("byte store lanes wrong");
  a_excl_fail: assert property (
    acc && op == 6'h36 && excl && !resv_o |-> ##3 done_o && !mem_o.req
    ##1 carry_o && !resv_o)
    else $error("failed conditional store misbehaved");
  a_excl_pass: assert property (
    acc && op == 6'h36 && excl && resv_o && !irq_i && !exc_i ##1
    !irq_i && !exc_i |-> ##2
    mem_o.req && mem_o.we && mem_o.addr[1:0] == 2'h0 && !resv_o && !carry_o)
    else $error("conditional store with reservation misbehaved");
  a_resv_load: assert property (
    acc && op == 6'h32 && excl |-> ##3 mem_o.req && !mem_o.we &&
    mem_o.addr[1:0] == 2'h0 && resv_o)
    else $error("reserving load misbehaved");
  a_event_clear: assert property (
    (irq_i || exc_i) && instr_ready_o |=> !resv_o)
    else $error("event left reservation set");
  a_reset_clear: assert property (
    $rose(rst_n_i) |-> !resv_o && !bip_o && !carry_o)
    else $error("flags not clear after reset");
  c_taken: cover property (done_o && taken_o && !delay_slot_o);
  c_excl_pass: cover property (acc && op == 6'h36 && excl && resv_o);
  c_mem_wait: cover property (mem_o.req && !mem_ack_i ##1 mem_ack_i);
endmodule // ibd_core_sva

bind ibd_core ibd_core_sva u_sva (.*);

// File: ibd_mem_model.sv
// behavioural data memory answering the core's requests
`timescale 1ns/1ps
module ibd_mem_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // request side
  input ibd_pkg::ibd_mem_t mem_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:63];
  logic [3:0] wait_reg;
  // read data toggles whenever it is not due, so stale values never match
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'h0;
      wait_reg <= 4'h0;
      rdata_o <= 32'h0;
    end else if (!ack_o && mem_i.req && wait_reg >= lat_i) begin
      ack_o <= 1'h1;
      rdata_o <= mem[mem_i.addr[7:2]];
      for (int b = 0; b < 4; b++) begin
        if (mem_i.we && mem_i.be[b]) begin
          mem[mem_i.addr[7:2]][8*b+:8] <= mem_i.wdata[8*b+:8];
        end
      end
    end else begin
      ack_o <= 1'h0;
      wait_reg <= (mem_i.req && !ack_o) ? wait_reg + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule // ibd_mem_model

// File: ibd_core_tb_top.sv
// self-checking bench for the immediate branch and load/store core
`timescale 1ns/1ps
module ibd_core_tb_top;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic instr_valid_i = 1'h0;
  logic [31:0] instr_i = 32'h0;
  logic [31:0] instr_pc_i = 32'h0;
  logic irq_i = 1'h0;
  logic exc_i = 1'h0;
  logic bip_clear_i = 1'h0;
  logic [3:0] lat = 4'h0;
  logic instr_ready_o, done_o, taken_o, delay_slot_o, bip_o, carry_o, resv_o;
  logic mem_ack_i;
  logic [31:0] pc_next_o, mem_rdata_i;
  ibd_pkg::ibd_mem_t mem_o;
  logic [31:0] pc = 32'h100;
  logic tk;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  ibd_core dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_pc_i(instr_pc_i), .instr_ready_o(instr_ready_o),
    .done_o(done_o), .pc_next_o(pc_next_o), .taken_o(taken_o),
    .delay_slot_o(delay_slot_o), .irq_i(irq_i), .exc_i(exc_i),
    .bip_clear_i(bip_clear_i), .bip_o(bip_o), .carry_o(carry_o),
    .resv_o(resv_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i));
  ibd_mem_model u_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .mem_i(mem_o), .lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // ==================================================
  // common tasks
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask

  // offers one instruction, follows the core to its next fetch address
  task automatic run(input logic [31:0] ins);
    int n;
    n = 0;
    while (instr_ready_o !== 1'h1) tick();
    instr_valid_i = 1'h1;
    instr_i = ins;
    instr_pc_i = pc;
    tick();
    instr_valid_i = 1'h0;
    while (done_o !== 1'h1 && n < 40) begin
      tick();
      n++;
    end
    if (n == 40) chk(32'h0, 32'h1);
    tk = taken_o;
    pc = pc_next_o;
  endtask

  function automatic logic [31:0] ri(input logic [5:0] o,
      input logic [4:0] d, input logic [4:0] a, input logic [15:0] m);
    return {o, d, a, m};
  endfunction

  function automatic logic [31:0] rr(input logic [5:0] o,
      input logic [4:0] d, input logic [4:0] a, input logic [4:0] b,
      input logic [10:0] x);
    return {o, d, a, b, x};
  endfunction

  // ==================================================
  // scenarios
  task automatic t_mem();
    run(ri(6'h3A, 5'h1, 5'h0, 16'h0004));
    run(ri(6'h3A, 5'h2, 5'h0, 16'h0008));
    run(ri(6'h3A, 5'h3, 5'h0, 16'h000C));
    run(ri(6'h3A, 5'h7, 5'h0, 16'h0014));
    run(ri(6'h38, 5'h4, 5'h0, 16'h0011));
    run(rr(6'h31, 5'h5, 5'h7, 5'h7, 11'h000));
    run(ri(6'h3E, 5'h4, 5'h0, 16'h0020));
    run(ri(6'h3E, 5'h5, 5'h0, 16'h0024));
    run(ri(6'h3C, 5'h1, 5'h0, 16'h0029));
    run(ri(6'h3D, 5'h3, 5'h0, 16'h002E));
    run(rr(6'h30, 5'hA, 5'h7, 5'h7, 11'h000));
    run(rr(6'h32, 5'hB, 5'h7, 5'h7, 11'h000));
    run(ri(6'h39, 5'hC, 5'h7, 16'h000A));
    run(rr(6'h35, 5'hB, 5'h4, 5'h7, 11'h000));
    run(rr(6'h34, 5'hA, 5'h4, 5'h3, 11'h000));
    run(rr(6'h36, 5'hC, 5'h4, 5'h2, 11'h000));
    run(rr(6'h36, 5'h1, 5'h7, 5'h7, 11'h200));
    chk(u_mem.mem[8], 32'h000000B2);
    chk(u_mem.mem[9], 32'h0000A1B2);
    chk(u_mem.mem[10], 32'hFF00FFFF);
    chk(u_mem.mem[11], 32'hFFFF0005);
    chk(u_mem.mem[4], 32'h80000000);
    chk(u_mem.mem[44], 32'h0000C3D4);
    chk(u_mem.mem[45], 32'hFFFFFFA1);
    chk(u_mem.mem[46], 32'hFFFFC3D4);
  endtask

  // r1 negative, r2 zero, r3 positive against all six conditions
  task automatic t_cond();
    logic [31:0] p;
    logic e;
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 6; c++) begin
        for (int r = 1; r < 4; r++) begin
          case (c)
            0: e = (r == 2);
            1: e = (r != 2);
            2: e = (r == 1);
            3: e = (r != 3);
            4: e = (r == 3);
            default: e = (r != 1);
          endcase
          p = pc;
          run({6'h2F, 1'(d), 4'(c), 5'(r), 16'hFFF8});
          if (d == 1 && e) begin
            chk(pc, p + 32'h4);
            run(32'h0);
          end
          chk(32'(tk), 32'(e));
          chk(pc, e ? p + 32'hFFFFFFF8 : p + 32'h4);
        end
      end
    end
  endtask

  task automatic t_jumps();
    logic [4:0] sel [6] = '{5'h00, 5'h10, 5'h14, 5'h08, 5'h18, 5'h1C};
    logic [31:0] p;
    logic [31:0] t;
    for (int i = 0; i < 6; i++) begin
      p = pc;
      t = sel[i][3] ? 32'hFFFF8010 : p + 32'hFFFF8010;
      run({6'h2E, (sel[i][2] ? 5'h8 : 5'h0), sel[i], 16'h8010});
      if (sel[i][4]) begin
        chk(32'({tk, delay_slot_o}), 32'h1);
        chk(pc, p + 32'h4);
        run(32'h0);
      end
      chk(32'(tk), 32'h1);
      chk(pc, t);
      if (sel[i][2]) begin
        run(ri(6'h3E, 5'h8, 5'h0, 16'h0030));
        chk(u_mem.mem[12], p);
      end
    end
  endtask

  // slow memory here, so requests must hold while the memory stalls
  task automatic t_resv();
    logic [31:0] p;
    lat = 4'h3;
    run(rr(6'h32, 5'h6, 5'h7, 5'h3, 11'h400));
    chk(32'(resv_o), 32'h1);
    run(ri(6'h3E, 5'h6, 5'h0, 16'h0034));
    chk(u_mem.mem[13], 32'h00000005);
    run(rr(6'h36, 5'h3, 5'h7, 5'h7, 11'h400));
    tick();
    chk(u_mem.mem[4], 32'h00000005);
    chk(32'({carry_o, resv_o}), 32'h0);
    run(rr(6'h36, 5'h1, 5'h7, 5'h7, 11'h400));
    tick();
    chk(u_mem.mem[4], 32'h00000005);
    chk(32'(carry_o), 32'h1);
    for (int k = 0; k < 2; k++) begin
      run(rr(6'h32, 5'h6, 5'h7, 5'h0, 11'h400));
      irq_i = (k == 0);
      exc_i = (k == 1);
      tick();
      irq_i = 1'h0;
      exc_i = 1'h0;
      chk(32'(resv_o), 32'h0);
    end
    run(rr(6'h32, 5'h6, 5'h7, 5'h0, 11'h400));
    p = pc;
    run(ri(6'h2E, 5'h9, 5'h0C, 16'h0200));
    tick();
    chk(pc, 32'h00000200);
    chk(32'({bip_o, resv_o}), 32'h2);
    run(ri(6'h3E, 5'h9, 5'h0, 16'h0038));
    chk(u_mem.mem[14], p);
    bip_clear_i = 1'h1;
    tick();
    bip_clear_i = 1'h0;
    tick();
    chk(32'(bip_o), 32'h0);
    run(rr(6'h32, 5'h6, 5'h7, 5'h0, 11'h400));
    run(rr(6'h36, 5'h7, 5'h7, 5'h7, 11'h400));
    chk(32'({carry_o, resv_o}), 32'h0);
    chk(u_mem.mem[4], 32'h00000008);
  endtask

  // a reset in mid-run must drop every flag that is held
  task automatic t_reset();
    run(rr(6'h36, 5'h1, 5'h7, 5'h7, 11'h400));
    run(rr(6'h32, 5'h6, 5'h7, 5'h0, 11'h400));
    chk(32'({carry_o, resv_o}), 32'h3);
    rst_n_i = 1'h0;
    repeat (5) tick();
    rst_n_i = 1'h1;
    chk(32'({resv_o, bip_o, carry_o}), 32'h0);
    chk(u_mem.mem[4], 32'h00000008);
  endtask

  // ==================================================
  // main sequence and hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    u_mem.mem[1] = 32'h80000000;
    u_mem.mem[2] = 32'h00000000;
    u_mem.mem[3] = 32'h00000005;
    u_mem.mem[4] = 32'hA1B2C3D4;
    u_mem.mem[5] = 32'h00000008;
    u_mem.mem[10] = 32'hFFFFFFFF;
    u_mem.mem[11] = 32'hFFFFFFFF;
    u_mem.mem[45] = 32'hFFFFFFFF;
    u_mem.mem[46] = 32'hFFFFFFFF;
    repeat (5) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'h1;
    chk(32'({resv_o, bip_o, carry_o}), 32'h0);
    t_mem();
    t_cond();
    t_jumps();
    t_resv();
    t_reset();
    conclude();
  end
endmodule // ibd_core_tb_top
